// [design/can_io_defines.svh]
// Purpose: shared constants of the frame-level I/O node command link
// Assumes: frames carry an 11-bit identifier, a 4-bit length and 8 data bytes
// Notes: byte 0 of a payload sits in data bits [7:0]; least significant byte first
`ifndef CAN_IO_DEFINES_SVH
`define CAN_IO_DEFINES_SVH

// ==========================================================================
// widths
`define CIO_ID_W 11
`define CIO_NODE_W 7
`define CIO_DLC_W 4
`define CIO_DATA_W 64
`define CIO_DIO_W 12
`define CIO_AO_N 4
`define CIO_AO_W 16

// ==========================================================================
// frame identifier bases, node identifier is added to each except the management base
`define CIO_ID_NMT 11'h000
`define CIO_ID_DIN 11'h180
`define CIO_ID_DOUT 11'h200
`define CIO_ID_AOUT 11'h300
`define CIO_ID_BOOT 11'h700

// ==========================================================================
// management command bytes
`define CIO_NMT_RESET 8'h81
`define CIO_NMT_START 8'h01

// ==========================================================================
// payload lengths
`define CIO_DLC_NMT 4'h2
`define CIO_DLC_DOUT 4'h2
`define CIO_DLC_AOUT 4'h8
`define CIO_DLC_POLL 4'h0
`define CIO_DLC_DIN 4'h2
`define CIO_DLC_BOOT 4'h8

// ==========================================================================
// fixed payloads and reset values
`define CIO_BOOT_DATA 64'h0807060504030201
`define CIO_DOUT_RST 12'h000
`define CIO_AOUT_RST 64'h0000000000000000
`define CIO_NODE_RST 7'h00

`endif

// [design/can_io_pkg.sv]
// Purpose: types shared by both ends of the I/O node command link
// Assumes: constants come from can_io_defines.svh
// Notes: frame_id builds and checks base-plus-node identifiers
`include "can_io_defines.svh"

package can_io_pkg;

    // ======================================================================
    // node life-cycle states
    typedef enum logic [1:0] {
        st_init = 2'b00, // initialising, boot frame pending
        st_preop = 2'b01, // pre-operational, settings may change
        st_oper = 2'b10 // operational, process data live
    } node_state_e;

    // ======================================================================
    // commands the master end can issue
    typedef enum logic [2:0] {
        cmd_reset = 3'b000, // management reset
        cmd_start = 3'b001, // management start
        cmd_dout = 3'b010, // digital output frame
        cmd_aout = 3'b011, // analog output frame
        cmd_poll = 3'b100 // digital input poll
    } cmd_kind_e;

    typedef logic [`CIO_ID_W-1:0] can_id_t;

    // base identifier plus node identifier
    function automatic can_id_t frame_id(input can_id_t base, input logic [`CIO_NODE_W-1:0] node);
        frame_id = can_id_t'(base + {4'h0, node});
    endfunction

endpackage

// [design/can_frame_if.sv]
// Purpose: frame carrier between master end and node end
// Assumes: both ends share one clock; valid/ready handshake per direction
// Notes: a frame moves on a cycle where valid and ready are both high
`timescale 1ns/1ps
`default_nettype none
`include "can_io_defines.svh"

interface can_frame_if;
    // master to node
    logic m2d_valid;
    logic m2d_ready;
    logic [`CIO_ID_W-1:0] m2d_id;
    logic [`CIO_DLC_W-1:0] m2d_dlc;
    logic [`CIO_DATA_W-1:0] m2d_data;
    // node to master
    logic d2m_valid;
    logic d2m_ready;
    logic [`CIO_ID_W-1:0] d2m_id;
    logic [`CIO_DLC_W-1:0] d2m_dlc;
    logic [`CIO_DATA_W-1:0] d2m_data;

    modport node (
        input m2d_valid, m2d_id, m2d_dlc, m2d_data, d2m_ready,
        output m2d_ready, d2m_valid, d2m_id, d2m_dlc, d2m_data
    );
    modport master (
        output m2d_valid, m2d_id, m2d_dlc, m2d_data, d2m_ready,
        input m2d_ready, d2m_valid, d2m_id, d2m_dlc, d2m_data
    );
endinterface

`default_nettype wire

// [design/can_io_node.sv]
// Purpose: node end, decodes management and process-data frames of an I/O node
// Assumes: one 20 MHz clock, synchronous active-low reset, frame-level link
// Notes: node identifier is sampled while initialising; inputs pass 3 flops
// Contract
// RULE1 - reset frame 81h plus node reinitialises
// RULE2 - boot frame 700h+node, bytes 01h..08h
// RULE3 - init state then pre-operational after reset
// RULE4 - start frame 01h enters operational, silently
// RULE5 - digital I/O only when operational
// RULE6 - 200h+node drives twelve outputs, no ack
// RULE7 - output one is byte0 bit0
// RULE8 - each output frame replaces all twelve
// RULE9 - empty 180h+node poll gets two-byte reply
// RULE10 - inputs 1-8 byte0, 9-12 byte1, high=1
// RULE11 - 300h+node carries four 16-bit values
// RULE12 - one frame updates all four together
// RULE13 - analog count is ten millivolts
// RULE14 - analog frame gets no ack or error
// RULE15 - multi-byte values least significant byte first
// RULE16 - process data only in operational state
// RULE17 - ignore frames for other node identifiers
`timescale 1ns/1ps
`default_nettype none
`include "can_io_defines.svh"

module can_io_node
    import can_io_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    can_frame_if.node link,
    input wire logic [`CIO_NODE_W-1:0] node_identifier,
    input wire logic [`CIO_DIO_W-1:0] digital_input_line,
    output logic [`CIO_DIO_W-1:0] digital_output,
    output logic [`CIO_AO_N-1:0][`CIO_AO_W-1:0] analog_output_channel,
    output logic analog_update,
    output node_state_e node_state
);

    // ======================================================================
    // state and storage
    node_state_e state_q; // life-cycle state
    logic [`CIO_NODE_W-1:0] node_q; // sampled node identifier
    logic [`CIO_DIO_W-1:0] din_s1_q; // first sync stage, read by s2 only
    logic [`CIO_DIO_W-1:0] din_s2_q; // second sync stage
    logic [`CIO_DIO_W-1:0] din_s3_q; // third sync stage
    logic [`CIO_DIO_W-1:0] din_q; // settled input levels
    logic [`CIO_DIO_W-1:0] dout_q; // digital output latch
    logic [`CIO_AO_N-1:0][`CIO_AO_W-1:0] aout_q; // analog output latch
    logic aupd_q; // analog update pulse
    logic tx_valid_q; // outgoing frame pending
    can_id_t tx_id_q; // outgoing identifier
    logic [`CIO_DLC_W-1:0] tx_dlc_q; // outgoing length
    logic [`CIO_DATA_W-1:0] tx_data_q; // outgoing payload

    // ======================================================================
    // receive decode
    logic rx_take; // frame taken this cycle
    logic is_nmt; // addressed management frame
    logic nmt_reset; // reset command for this node
    logic nmt_start; // start command for this node
    logic is_oper; // operational state
    logic pdo_dout; // digital output frame accepted
    logic pdo_aout; // analog output frame accepted
    logic pdo_poll; // input poll accepted
    logic tx_done; // outgoing frame handed over

    // no new frame while a reply is pending or while initialising
    assign link.m2d_ready = !tx_valid_q && (state_q != st_init);
    assign rx_take = link.m2d_valid && link.m2d_ready;
    assign tx_done = link.d2m_valid && link.d2m_ready;
    assign is_oper = (state_q == st_oper);

    // management frame must name this node in its second byte
    assign is_nmt = rx_take && (link.m2d_id == `CIO_ID_NMT)
        && (link.m2d_dlc == `CIO_DLC_NMT)
        && (link.m2d_data[15:8] == {1'b0, node_q}); // see RULE17
    assign nmt_reset = is_nmt && (link.m2d_data[7:0] == `CIO_NMT_RESET); // see RULE1
    assign nmt_start = is_nmt && (link.m2d_data[7:0] == `CIO_NMT_START); // see RULE4

    // process-data frames only match base plus own node, only when operational
    assign pdo_dout = rx_take && is_oper
        && (link.m2d_id == frame_id(`CIO_ID_DOUT, node_q))
        && (link.m2d_dlc >= `CIO_DLC_DOUT); // see RULE5 see RULE16 see RULE17
    assign pdo_aout = rx_take && is_oper
        && (link.m2d_id == frame_id(`CIO_ID_AOUT, node_q))
        && (link.m2d_dlc == `CIO_DLC_AOUT); // see RULE16 see RULE17
    assign pdo_poll = rx_take && is_oper
        && (link.m2d_id == frame_id(`CIO_ID_DIN, node_q))
        && (link.m2d_dlc == `CIO_DLC_POLL); // see RULE9 see RULE16 see RULE17

    // ======================================================================
    // life-cycle state machine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= st_init;
        end else begin
            unique case (state_q)
                // boot frame loaded this cycle, then settle
                st_init: begin
                    state_q <= st_preop; // see RULE3
                end
                // wait for start command
                st_preop: begin
                    if (nmt_reset) begin
                        state_q <= st_init; // see RULE1
                    end else if (nmt_start) begin
                        state_q <= st_oper; // see RULE4
                    end
                end
                // operational until reset command
                st_oper: begin
                    if (nmt_reset) begin
                        state_q <= st_init; // see RULE1
                    end
                end
                // unused code recovers through init
                default: begin
                    state_q <= st_init;
                end
            endcase
        end
    end

    // ======================================================================
    // node identifier caught in the init state after reset release or a reset command, held otherwise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            node_q <= `CIO_NODE_RST;
        end else if (state_q == st_init) begin
            node_q <= node_identifier;
        end
    end

    // ======================================================================
    // input pins: three flops, change taken once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            din_s1_q <= '0;
            din_s2_q <= '0;
            din_s3_q <= '0;
            din_q <= '0;
        end else begin
            din_s1_q <= digital_input_line;
            din_s2_q <= din_s1_q;
            din_s3_q <= din_s2_q;
            // per bit: keep old level while stages disagree
            din_q <= (din_s2_q & din_s3_q) | (din_q & (din_s2_q ^ din_s3_q));
        end
    end

    // ======================================================================
    // digital outputs, whole word replaced per frame
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dout_q <= `CIO_DOUT_RST;
        end else if (nmt_reset) begin
            dout_q <= `CIO_DOUT_RST; // see RULE1
        end else if (pdo_dout) begin
            // byte0 bit0 is output one, byte1 bit3 output twelve
            dout_q <= link.m2d_data[`CIO_DIO_W-1:0]; // see RULE6 see RULE7 see RULE8
        end
    end

    // ======================================================================
    // analog outputs, raw counts of 10 mV, all four at once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aout_q <= `CIO_AOUT_RST;
        end else if (nmt_reset) begin
            aout_q <= `CIO_AOUT_RST; // see RULE1
        end else if (pdo_aout) begin
            // low byte first: bytes 0-1 channel one, 6-7 channel four
            for (int i = 0; i < `CIO_AO_N; i++) begin
                aout_q[i] <= link.m2d_data[i*`CIO_AO_W +: `CIO_AO_W]; // see RULE11 see RULE15
            end
            // zero count drives zero volts; see RULE12 see RULE13
        end
    end

    // one-cycle strobe marks a joint update of all channels
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aupd_q <= 1'b0;
        end else begin
            aupd_q <= pdo_aout; // see RULE12
        end
    end

    // ======================================================================
    // transmit slot: boot frame or input reply, nothing else answers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_valid_q <= 1'b0;
            tx_id_q <= '0;
            tx_dlc_q <= '0;
            tx_data_q <= '0;
        end else if (state_q == st_init) begin
            // announce boot with fixed byte pattern
            tx_valid_q <= 1'b1;
            tx_id_q <= frame_id(`CIO_ID_BOOT, node_identifier); // see RULE2
            tx_dlc_q <= `CIO_DLC_BOOT;
            tx_data_q <= `CIO_BOOT_DATA; // see RULE2
        end else if (pdo_poll) begin
            // reply on the poll identifier, inputs 1-8 then 9-12
            tx_valid_q <= 1'b1;
            tx_id_q <= link.m2d_id; // see RULE9
            tx_dlc_q <= `CIO_DLC_DIN;
            tx_data_q <= {52'h0, din_q}; // see RULE10 see RULE15
        end else if (tx_done) begin
            tx_valid_q <= 1'b0;
        end
        // start, output and analog frames queue nothing; see RULE4 see RULE6 see RULE14
    end

    // ======================================================================
    // outputs
    assign link.d2m_valid = tx_valid_q;
    assign link.d2m_id = tx_id_q;
    assign link.d2m_dlc = tx_dlc_q;
    assign link.d2m_data = tx_data_q;
    assign digital_output = dout_q;
    assign analog_output_channel = aout_q;
    assign analog_update = aupd_q;
    assign node_state = state_q;

endmodule

`default_nettype wire

// [design/can_io_master.sv]
// Purpose: master end, turns user commands into frames and returns replies
// Assumes: one 20 MHz clock, synchronous active-low reset
// Notes: one command in flight; replies always accepted
`timescale 1ns/1ps
`default_nettype none
`include "can_io_defines.svh"

module can_io_master
    import can_io_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    can_frame_if.master link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire cmd_kind_e cmd_kind,
    input wire logic [`CIO_NODE_W-1:0] cmd_node,
    input wire logic [`CIO_DATA_W-1:0] cmd_payload,
    output logic rsp_valid,
    output logic [`CIO_ID_W-1:0] rsp_id,
    output logic [`CIO_DLC_W-1:0] rsp_dlc,
    output logic [`CIO_DATA_W-1:0] rsp_data
);

    // ======================================================================
    // outgoing frame register
    logic tx_valid_q; // frame offered to node
    can_id_t tx_id_q; // its identifier
    logic [`CIO_DLC_W-1:0] tx_dlc_q; // its length
    logic [`CIO_DATA_W-1:0] tx_data_q; // its payload
    logic rsp_valid_q; // reply strobe
    can_id_t rsp_id_q; // reply identifier
    logic [`CIO_DLC_W-1:0] rsp_dlc_q; // reply length
    logic [`CIO_DATA_W-1:0] rsp_data_q; // reply payload
    logic cmd_take; // command taken this cycle

    assign cmd_ready = !tx_valid_q;
    assign cmd_take = cmd_valid && cmd_ready;

    // ======================================================================
    // frame builder, payloads low byte first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_valid_q <= 1'b0;
            tx_id_q <= '0;
            tx_dlc_q <= '0;
            tx_data_q <= '0;
        end else if (cmd_take) begin
            tx_valid_q <= 1'b1;
            unique case (cmd_kind)
                // management frames carry command byte then node
                cmd_reset: begin
                    tx_id_q <= `CIO_ID_NMT;
                    tx_dlc_q <= `CIO_DLC_NMT;
                    tx_data_q <= {48'h0, 1'b0, cmd_node, `CIO_NMT_RESET}; // see RULE1
                end
                cmd_start: begin
                    tx_id_q <= `CIO_ID_NMT;
                    tx_dlc_q <= `CIO_DLC_NMT;
                    tx_data_q <= {48'h0, 1'b0, cmd_node, `CIO_NMT_START}; // see RULE4
                end
                // full twelve-bit output word each time
                cmd_dout: begin
                    tx_id_q <= frame_id(`CIO_ID_DOUT, cmd_node);
                    tx_dlc_q <= `CIO_DLC_DOUT;
                    tx_data_q <= {52'h0, cmd_payload[`CIO_DIO_W-1:0]}; // see RULE6 see RULE7 see RULE8
                end
                // four channels of 10 mV counts, channel one in bytes 0-1; see RULE13
                cmd_aout: begin
                    tx_id_q <= frame_id(`CIO_ID_AOUT, cmd_node);
                    tx_dlc_q <= `CIO_DLC_AOUT;
                    tx_data_q <= cmd_payload; // see RULE11 see RULE12 see RULE15
                end
                // empty poll frame
                cmd_poll: begin
                    tx_id_q <= frame_id(`CIO_ID_DIN, cmd_node);
                    tx_dlc_q <= `CIO_DLC_POLL;
                    tx_data_q <= '0;
                end
                // unused kind sends nothing
                default: begin
                    tx_valid_q <= 1'b0;
                end
            endcase
        end else if (link.m2d_ready) begin
            tx_valid_q <= 1'b0;
        end
    end

    // ======================================================================
    // reply capture, one-cycle strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp_valid_q <= 1'b0;
            rsp_id_q <= '0;
            rsp_dlc_q <= '0;
            rsp_data_q <= '0;
        end else begin
            rsp_valid_q <= link.d2m_valid;
            if (link.d2m_valid) begin
                rsp_id_q <= link.d2m_id;
                rsp_dlc_q <= link.d2m_dlc;
                rsp_data_q <= link.d2m_data;
            end
        end
    end

    // ======================================================================
    // outputs
    assign link.m2d_valid = tx_valid_q;
    assign link.m2d_id = tx_id_q;
    assign link.m2d_dlc = tx_dlc_q;
    assign link.m2d_data = tx_data_q;
    assign link.d2m_ready = 1'b1;
    assign rsp_valid = rsp_valid_q;
    assign rsp_id = rsp_id_q;
    assign rsp_dlc = rsp_dlc_q;
    assign rsp_data = rsp_data_q;

endmodule

`default_nettype wire

// [sim/can_link_checker.sv]
// Purpose: carrier checker for the node command link
// Assumes: one clock, synchronous active-low reset
// Notes: sees carrier signals only, so the node identifier is unknown here
`timescale 1ns/1ps
`default_nettype none

module can_link_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic m2d_valid,
    input wire logic m2d_ready,
    input wire logic [10:0] m2d_id,
    input wire logic [3:0] m2d_dlc,
    input wire logic [63:0] m2d_data,
    input wire logic d2m_valid,
    input wire logic d2m_ready,
    input wire logic [10:0] d2m_id,
    input wire logic [3:0] d2m_dlc,
    input wire logic [63:0] d2m_data
);
    // ======================================================================
    // helper terms
    logic take; // frame accepted by the node
    logic rst_take; // reset management frame accepted
    logic boot; // node offers a boot frame
    logic quiet_cmd; // frames that never earn an answer
    assign take = m2d_valid && m2d_ready;
    assign rst_take = take && m2d_id == 11'h000 && m2d_data[7:0] == 8'h81;
    assign boot = d2m_valid && d2m_id[10:7] == 4'he;
    assign quiet_cmd = m2d_id[10:9] == 2'b01 || (m2d_id == 11'h000 && m2d_data[7:0] == 8'h01);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ======================================================================
    // assertions
    AST_BOOT_PAYLOAD: assert property (
        boot |-> d2m_dlc == 4'h8 && d2m_data == 64'h0807060504030201)
        else $error("boot frame payload wrong");
    AST_BOOT_CAUSE: assert property (
        boot |-> $past(rst_take, 2) || !$past(rst_n, 2))
        else $error("boot frame without reset two cycles before");
    AST_POLL_REPLY: assert property (
        d2m_valid && d2m_id[10:7] == 4'h3 |-> d2m_dlc == 4'h2 && d2m_data[63:12] == 52'h0
            && $past(take) && $past(m2d_id) == d2m_id && $past(m2d_dlc) == 4'h0)
        else $error("input reply not one cycle after its poll");
    AST_NO_ACK: assert property (
        take && quiet_cmd |=> !d2m_valid [*2])
        else $error("node answered a silent frame");
    AST_BLOCK_WHILE_PENDING: assert property (
        d2m_valid |-> !m2d_ready)
        else $error("node ready while its own frame pending");
    AST_HOLD_OFFER: assert property (
        m2d_valid && !m2d_ready |=> m2d_valid && $stable(m2d_id) && $stable(m2d_data))
        else $error("master dropped or changed an offered frame");
    AST_REPLY_ONE_CYCLE: assert property (
        d2m_valid |=> !d2m_valid)
        else $error("node frame stood longer than one cycle");
    AST_REPLY_KINDS: assert property (
        d2m_valid |-> d2m_id[10:7] == 4'h3 || d2m_id[10:7] == 4'he)
        else $error("node sent an unexpected frame kind");
    AST_MASTER_DROP: assert property (
        take |=> !m2d_valid)
        else $error("master kept valid after acceptance");
endmodule

`default_nettype wire

// [sim/tb_top.sv]
// Purpose: drives the master user side and the node pins, checks both ends
// Assumes: 20 MHz clock, node strap fixed at NODE
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "can_io_defines.svh"

module tb_top
    import can_io_pkg::*;
;
    localparam logic [6:0] NODE = 7'h05; // own node identifier
    localparam logic [6:0] OTHER = 7'h06; // a foreign node
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] digital_input_line = 12'h000;
    logic [11:0] digital_output;
    logic [3:0][15:0] analog_output_channel;
    logic analog_update;
    node_state_e node_state;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    cmd_kind_e cmd_kind = cmd_reset;
    logic [6:0] cmd_node = 7'h00;
    logic [63:0] cmd_payload = 64'h0;
    logic rsp_valid;
    logic [10:0] rsp_id;
    logic [3:0] rsp_dlc;
    logic [63:0] rsp_data;
    logic [63:0] last_ao = 64'h0; // last analog frame seen on the wire
    logic [11:0] dout_tab [4] = '{12'h001, 12'h800, 12'hfff, 12'h020};
    logic [11:0] din_tab [2] = '{12'h801, 12'h7fe};
    int n_errors = 0;
    int n_compared = 0;
    bit got; // a reply arrived

    // ======================================================================
    // clock, ends and checker
    always #25 clk = ~clk;

    can_frame_if link_if ();

    can_io_node i_can_io_node (.clk(clk), .rst_n(rst_n), .link(link_if.node),
        .node_identifier(NODE), .digital_input_line(digital_input_line),
        .digital_output(digital_output), .analog_output_channel(analog_output_channel),
        .analog_update(analog_update), .node_state(node_state));

    can_io_master i_can_io_master (.clk(clk), .rst_n(rst_n), .link(link_if.master),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
        .cmd_node(cmd_node), .cmd_payload(cmd_payload), .rsp_valid(rsp_valid),
        .rsp_id(rsp_id), .rsp_dlc(rsp_dlc), .rsp_data(rsp_data));

    can_link_checker i_can_link_checker (.clk(clk), .rst_n(rst_n),
        .m2d_valid(link_if.m2d_valid), .m2d_ready(link_if.m2d_ready),
        .m2d_id(link_if.m2d_id), .m2d_dlc(link_if.m2d_dlc), .m2d_data(link_if.m2d_data),
        .d2m_valid(link_if.d2m_valid), .d2m_ready(link_if.d2m_ready),
        .d2m_id(link_if.d2m_id), .d2m_dlc(link_if.d2m_dlc), .d2m_data(link_if.d2m_data));

    // wire watch, sampled mid-cycle when the carrier is settled
    always @(negedge clk) begin
        if (link_if.m2d_valid && link_if.m2d_ready && link_if.m2d_id == 11'h300 + NODE) begin
            last_ao = link_if.m2d_data;
        end
    end

    // ======================================================================
    // tasks
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [63:0] got_v, input logic [63:0] exp_v);
        n_compared++;
        if (got_v !== exp_v) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got_v, exp_v);
        end
    endtask

    // one command, returns 1 ns after the clock edge on which the node took the frame
    task automatic send(input cmd_kind_e k, input logic [6:0] n, input logic [63:0] p);
        int i = 0;
        cmd_kind = k;
        cmd_node = n;
        cmd_payload = p;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && i < 50) begin
            tick();
            i++;
        end
        if (i >= 50) begin
            n_errors++;
            $display("BAD %0t command not taken", $time);
        end
        tick();
        cmd_valid = 1'b0;
        tick();
    endtask

    task automatic wait_rsp(input int lim);
        got = 1'b0;
        repeat (lim) begin
            if (!got) begin
                tick();
                got = (rsp_valid === 1'b1);
            end
        end
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ======================================================================
    // watchdog, far beyond the hundred or so cycles the run needs
    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end

    // ======================================================================
    // main sequence
    initial begin
        repeat (20) tick();
        rst_n = 1'b1;
        wait_rsp(10);
        chk(got, 64'h1);
        chk(rsp_id, 64'h700 + NODE);
        chk(rsp_data, 64'h0807060504030201);
        chk(node_state, st_preop);
        // process data refused before start
        send(cmd_dout, NODE, 64'hfff);
        chk(digital_output, 64'h0);
        send(cmd_poll, NODE, 64'h0);
        wait_rsp(8);
        chk(got, 64'h0);
        send(cmd_start, OTHER, 64'h0);
        chk(node_state, st_preop);
        send(cmd_start, NODE, 64'h0);
        chk(node_state, st_oper);
        wait_rsp(6);
        chk(got, 64'h0);
        // digital outputs, each frame replaces all twelve
        for (int k = 0; k < 4; k++) begin
            send(cmd_dout, NODE, {52'h0, dout_tab[k]});
            chk(digital_output, dout_tab[k]);
        end
        send(cmd_dout, OTHER, 64'h5);
        chk(digital_output, 64'h020);
        // analog outputs, 350 counts is 3.5 V on channel one
        send(cmd_aout, NODE, 64'h019000c80000015e);
        chk(analog_update, 64'h1);
        chk(analog_output_channel, 64'h019000c80000015e);
        chk(analog_output_channel[0], 64'h15e);
        chk({last_ao[7:0], last_ao[15:8]}, 64'h5e01);
        chk(last_ao[7:0], 64'h5e);
        wait_rsp(6);
        chk(got, 64'h0);
        send(cmd_aout, NODE, 64'h0);
        chk(analog_output_channel, 64'h0);
        // input polls
        for (int k = 0; k < 2; k++) begin
            digital_input_line = din_tab[k];
            repeat (6) tick();
            send(cmd_poll, NODE, 64'h0);
            wait_rsp(8);
            chk(got, 64'h1);
            chk(rsp_id, 64'h180 + NODE);
            chk(rsp_dlc, 64'h2);
            chk(rsp_data, {52'h0, din_tab[k]});
        end
        send(cmd_poll, OTHER, 64'h0);
        wait_rsp(8);
        chk(got, 64'h0);
        // reset management frames
        send(cmd_reset, OTHER, 64'h0);
        wait_rsp(8);
        chk(got, 64'h0);
        send(cmd_reset, NODE, 64'h0);
        wait_rsp(10);
        chk(got, 64'h1);
        chk(rsp_id, 64'h700 + NODE);
        chk(node_state, st_preop);
        chk(digital_output, 64'h0);
        report_and_stop();
    end
endmodule

`default_nettype wire
